// File: pmc_pkg.sv
// Package for the power mode controller: register map, field layout, modes.
// Assumes a classic Wishbone slave with 32-bit data, byte lanes in sel.
package pmc_pkg;

  localparam logic [7:0]  PCTL_ADDR      = 8'h00;  // power_control_reg
  localparam logic [7:0]  OSCC_ADDR      = 8'h04;  // internal_osc_control_reg
  localparam logic [7:0]  WAKE_ADDR      = 8'h08;  // wake source enables
  localparam logic [7:0]  STAT_ADDR      = 8'h0C;  // mode status
  localparam logic [7:0]  RESET_PC       = 8'h00;

  localparam int          IDLE_BIT       = 0;
  localparam int          STOP_BIT       = 1;
  localparam int          SUSPEND_BIT    = 5;
  localparam int          WAKE_CMP_BIT   = 0;
  localparam int          WAKE_MCD_BIT   = 1;
  localparam int          WAKE_WDT_BIT   = 2;

  localparam logic [5:0]  FLAGS_RESET    = 6'h00;
  localparam logic [7:0]  OSCC_RESET     = 8'h00;
  localparam logic [2:0]  WAKE_RESET     = 3'b110;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // Missing-clock detector timeout
  localparam int          MCD_TIMEOUT_US = 100;
  localparam int          CLK_MHZ        = 125;
  localparam int          MCD_CYCLES     = MCD_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP,
    PMC_SUSPEND
  } pmc_mode_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic int_osc_en;
    logic periph_clk_en;
    logic port_match_en;
  } pmc_gate_t;

endpackage

// File: pmc_ctrl.sv
// Power mode controller: idle, stop and suspend entry, clock gating, wake and reset.
// Assumes a classic Wishbone master and a core that pulses instr_done_i per instruction.
//
// What this block does
// - Idle halts CPU after setting instruction completes
// - Enabled interrupt clears idle and resumes CPU
// - Reset ending idle restarts fetch at zero
// - Watchdog keeps counting in idle, resets out
// - Stop halts oscillator, CPU and digital peripherals
// - Stop silences all except missing-clock detector
// - Stop ends only through a reset
// - Enabled missing-clock detector resets out of stop
// - Suspend halts CPU and oscillator, keeps port-match
// - Suspend wakes on port-match, comparator low, reset
// - Non-reset suspend wake resumes at next instruction
// - Reset ending suspend restarts from address zero
// - Mode bits read zero, bits 7:2 flags
`timescale 1ns/1ns
`default_nettype none
module pmc_ctrl #(
  parameter int MCD_CYCLES = pmc_pkg::MCD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        instr_done_i,
  input  wire logic        irq_pending_i,
  input  wire logic        port_match_i,
  input  wire logic        comparator_i,
  input  wire logic        wdt_expired_i,
  input  wire logic        ext_reset_i,
  output pmc_pkg::pmc_gate_t gate_o,
  output pmc_pkg::pmc_mode_t mode_o,
  output logic             sys_reset_o,
  output logic [7:0]       reset_pc_o,
  output logic             wake_irq_o
);

  localparam logic [31:0] ZERO_CNT = 32'h0000_0000;
  localparam logic [31:0] ONE_CNT  = 32'h0000_0001;

  pmc_pkg::pmc_mode_t mode;
  pmc_pkg::pmc_mode_t next_mode;
  logic [5:0]         general_flags;
  logic [7:0]         osc_ctrl;
  logic [2:0]         wake_en;
  logic               idle_req;
  logic               stop_req;
  logic               susp_req;
  logic [31:0]        mcd_cnt;
  logic               mcd_fire;
  logic               wdt_fire;
  logic               reset_evt;
  logic               susp_wake;
  logic               bus_req;
  logic               bus_wr;
  logic               bus_rd;
  logic               wr_pctl;
  logic               wr_oscc;
  logic               wr_wake;
  logic [31:0]        next_rd_data;

  // Register select on the low address byte
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // Oscillator and peripherals run wherever the CPU or its timers still need them
  function automatic logic osc_needed(input pmc_pkg::pmc_mode_t m);
    return (m == pmc_pkg::PMC_RUN) || (m == pmc_pkg::PMC_IDLE);
  endfunction

  // Every register is one byte wide; upper lanes read zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // A write needs byte lane 0; reads ignore sel
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd   = bus_req && !wb_we_i;
  assign wr_pctl  = bus_wr && hit(wb_adr_i, pmc_pkg::PCTL_ADDR);
  assign wr_oscc  = bus_wr && hit(wb_adr_i, pmc_pkg::OSCC_ADDR);
  assign wr_wake  = bus_wr && hit(wb_adr_i, pmc_pkg::WAKE_ADDR);

  // Counts only in stop, where the system clock is meant to be gone
  assign mcd_fire  = wake_en[pmc_pkg::WAKE_MCD_BIT]
                     && (mode == pmc_pkg::PMC_STOP)
                     && (mcd_cnt >= 32'(MCD_CYCLES - 1));
  // Watchdog keeps counting in idle; its expiry is a reset
  assign wdt_fire  = wdt_expired_i && wake_en[pmc_pkg::WAKE_WDT_BIT];
  assign reset_evt = ext_reset_i || mcd_fire || wdt_fire;
  assign susp_wake = port_match_i
                     || (wake_en[pmc_pkg::WAKE_CMP_BIT] && !comparator_i);

  // Read mux; mode select bits always read back as zero
  always_comb begin
    next_rd_data = pmc_pkg::ZERO_WORD;
    if (bus_rd) begin
      case (wb_adr_i)
        pmc_pkg::PCTL_ADDR: begin
          next_rd_data = byte_word({general_flags, 2'h0});
        end
        pmc_pkg::OSCC_ADDR: begin
          next_rd_data = byte_word(osc_ctrl);
        end
        pmc_pkg::WAKE_ADDR: begin
          next_rd_data = byte_word({5'h00, wake_en});
        end
        pmc_pkg::STAT_ADDR: begin
          next_rd_data = byte_word({6'h00, mode});
        end
        default: begin
          next_rd_data = pmc_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  // Single-cycle answer; ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Data stands only in the ack cycle of a read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= pmc_pkg::ZERO_WORD;
    end else begin
      wb_dat_o <= next_rd_data;
    end
  end

  // Flags survive every mode but not a reset
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      general_flags <= pmc_pkg::FLAGS_RESET;
    end else if (wr_pctl) begin
      general_flags <= wb_dat_i[7:2];
    end
  end

  // Suspend bit is a command, never stored
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      osc_ctrl <= pmc_pkg::OSCC_RESET;
    end else if (wr_oscc) begin
      osc_ctrl <= wb_dat_i[7:0] & ~(8'h01 << pmc_pkg::SUSPEND_BIT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      wake_en <= pmc_pkg::WAKE_RESET;
    end else if (wr_wake) begin
      wake_en <= wb_dat_i[2:0];
    end
  end

  // Requests wait for the setting instruction to complete; dropped outside run
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt || mode != pmc_pkg::PMC_RUN) begin
      idle_req <= 1'b0;
    end else if (wr_pctl && wb_dat_i[pmc_pkg::IDLE_BIT]) begin
      idle_req <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt || mode != pmc_pkg::PMC_RUN) begin
      stop_req <= 1'b0;
    end else if (wr_pctl && wb_dat_i[pmc_pkg::STOP_BIT]) begin
      stop_req <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt || mode != pmc_pkg::PMC_RUN) begin
      susp_req <= 1'b0;
    end else if (wr_oscc && wb_dat_i[pmc_pkg::SUSPEND_BIT]) begin
      susp_req <= 1'b1;
    end
  end

  // Deepest request wins when several land together
  always_comb begin
    next_mode = mode;
    case (mode)
      pmc_pkg::PMC_RUN: begin
        if (instr_done_i) begin
          if (stop_req) begin
            next_mode = pmc_pkg::PMC_STOP;
          end else if (susp_req) begin
            next_mode = pmc_pkg::PMC_SUSPEND;
          end else if (idle_req) begin
            next_mode = pmc_pkg::PMC_IDLE;
          end
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (irq_pending_i) begin
          next_mode = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_STOP: begin
        // Only a reset event leaves stop
        next_mode = pmc_pkg::PMC_STOP;
      end
      pmc_pkg::PMC_SUSPEND: begin
        if (susp_wake) begin
          next_mode = pmc_pkg::PMC_RUN;
        end
      end
      default: begin
        next_mode = pmc_pkg::PMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      mode <= pmc_pkg::PMC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Missing-clock timeout counter, cleared outside stop
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != pmc_pkg::PMC_STOP) begin
      mcd_cnt <= ZERO_CNT;
    end else begin
      mcd_cnt <= mcd_cnt + ONE_CNT;
    end
  end

  // Gates follow the next mode so they change with mode_o
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      gate_o.cpu_clk_en    <= 1'b1;
      gate_o.int_osc_en    <= 1'b1;
      gate_o.periph_clk_en <= 1'b1;
      gate_o.port_match_en <= 1'b1;
    end else begin
      gate_o.cpu_clk_en    <= (next_mode == pmc_pkg::PMC_RUN);
      gate_o.int_osc_en    <= osc_needed(next_mode);
      gate_o.periph_clk_en <= osc_needed(next_mode);
      gate_o.port_match_en <= (next_mode != pmc_pkg::PMC_STOP);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      mode_o <= pmc_pkg::PMC_RUN;
    end else begin
      mode_o <= next_mode;
    end
  end

  // Core restart rises one cycle after any reset and stays high for as long as the reset lasts
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= 1'b0;
    end
  end

  // Restart address is fixed
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      reset_pc_o <= pmc_pkg::RESET_PC;
    end else begin
      reset_pc_o <= pmc_pkg::RESET_PC;
    end
  end

  // Interrupt service after wake rides on the core's own pending line
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_evt) begin
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= (mode == pmc_pkg::PMC_SUSPEND) && susp_wake
                    && irq_pending_i;
    end
  end

endmodule
`default_nettype wire

// File: pmc_ctrl_properties.sv
// Checker for pmc_ctrl: bus handshake, mode gating and wake paths.
// Assumes the bind below; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module pmc_ctrl_chk (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic        [31:0] wb_dat_o,
  input wire logic               irq_pending_i,
  input wire logic               port_match_i,
  input wire logic               ext_reset_i,
  input wire pmc_pkg::pmc_gate_t gate_o,
  input wire pmc_pkg::pmc_mode_t mode_o,
  input wire logic               sys_reset_o,
  input wire logic        [7:0]  reset_pc_o,
  input wire logic               wake_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_back_to_run;
    ##[1:3] mode_o == pmc_pkg::PMC_RUN;
  endsequence
  sequence s_stop_left;
    mode_o == pmc_pkg::PMC_STOP ##1 mode_o != pmc_pkg::PMC_STOP;
  endsequence
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
  a_idle_gates: assert property (mode_o == pmc_pkg::PMC_IDLE |-> !gate_o.cpu_clk_en && gate_o.int_osc_en)
    else $error("idle gating wrong");
  a_stop_gates: assert property (mode_o == pmc_pkg::PMC_STOP |-> gate_o[3:1] == 3'h0)
    else $error("stop gating wrong");
  a_susp_gates: assert property (mode_o == pmc_pkg::PMC_SUSPEND |-> gate_o == 4'h1)
    else $error("suspend gating wrong");
  a_idle_wake: assert property (mode_o == pmc_pkg::PMC_IDLE && irq_pending_i |-> s_back_to_run)
    else $error("idle did not wake");
  a_susp_wake: assert property (mode_o == pmc_pkg::PMC_SUSPEND && port_match_i |-> s_back_to_run)
    else $error("suspend did not wake");
  a_stop_hold: assert property (s_stop_left |-> sys_reset_o && mode_o == pmc_pkg::PMC_RUN)
    else $error("stop left wrongly");
  a_reset_run: assert property (sys_reset_o |-> mode_o == pmc_pkg::PMC_RUN && gate_o == 4'hF)
    else $error("reset state wrong");
  a_reset_pc: assert property (sys_reset_o |-> reset_pc_o == 8'h00)
    else $error("restart address wrong");
  a_wake_irq: assert property (wake_irq_o |-> mode_o == pmc_pkg::PMC_RUN && $past(mode_o) == pmc_pkg::PMC_SUSPEND)
    else $error("wake interrupt wrong");
endmodule
bind pmc_ctrl pmc_ctrl_chk pmc_ctrl_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_pending_i(irq_pending_i), .port_match_i(port_match_i),
  .ext_reset_i(ext_reset_i), .gate_o(gate_o), .mode_o(mode_o), .sys_reset_o(sys_reset_o),
  .reset_pc_o(reset_pc_o), .wake_irq_o(wake_irq_o));
`default_nettype wire

// File: pmc_core_model.sv
// Core stand-in: finishes one instruction every third cycle while its clock runs.
// Assumes cpu_run_i is the controller's CPU clock gate.
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cpu_run_i,
  output logic      instr_done_o
);
  logic [1:0] phase;
  // A halted core completes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i || !cpu_run_i) begin
      phase <= 2'h0;
      instr_done_o <= 1'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      instr_done_o <= (phase == 2'h2);
    end
  end
endmodule
`default_nettype wire

// File: tb_pmc_ctrl.sv
// Testbench for pmc_ctrl: registers, idle, stop and suspend entry and exit.
// Assumes pmc_core_model supplies instruction completions.
`timescale 1ns/1ns
`default_nettype none
module tb_pmc_ctrl;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, irq = 1'h0, pm = 1'h0, cmp = 1'h1, ext = 1'h0, idn, ack;
  logic               xrst = 1'h0, srst, wirq;
  logic [7:0]         adr = 8'h00, rpc;
  logic [31:0]        dat = 32'h0000_0000, dat_o, rd;
  pmc_pkg::pmc_gate_t gate;
  pmc_pkg::pmc_mode_t mode;
  int                 err_count = 0, samples_checked = 0;
  always #4 clk_i = ~clk_i;
  pmc_ctrl #(.MCD_CYCLES(20)) pmc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .instr_done_i(idn), .irq_pending_i(irq), .port_match_i(pm), .comparator_i(cmp), .wdt_expired_i(ext),
    .ext_reset_i(xrst), .gate_o(gate), .mode_o(mode), .sys_reset_o(srst), .reset_pc_o(rpc), .wake_irq_o(wirq));
  pmc_core_model pmc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cpu_run_i(gate.cpu_clk_en), .instr_done_o(idn));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    rd = dat_o;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wmode(input pmc_pkg::pmc_mode_t m, input int lim);
    for (int n = 0; n < lim && mode !== m; n++) @(posedge clk_i);
    chk("mode", 32'(mode), 32'(m));
  endtask
  task automatic t_regs();
    wb(1'h1, pmc_pkg::PCTL_ADDR, 32'h0000_00FC);
    wb(1'h0, pmc_pkg::PCTL_ADDR, 32'h0000_0000);
    chk("flags", rd, 32'h0000_00FC);
    wb(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    $display("regs done");
  endtask
  task automatic t_idle();
    wb(1'h1, pmc_pkg::PCTL_ADDR, 32'h0000_0001);
    wmode(pmc_pkg::PMC_IDLE, 20);
    irq <= 1'h1;
    wmode(pmc_pkg::PMC_RUN, 5);
    irq <= 1'h0;
    wb(1'h1, pmc_pkg::PCTL_ADDR, 32'h0000_0001);
    wmode(pmc_pkg::PMC_IDLE, 20);
    ext <= 1'h1;
    @(posedge clk_i);
    ext <= 1'h0;
    wmode(pmc_pkg::PMC_RUN, 5);
    chk("wdt reset", 32'(srst), 32'h0000_0001);
    $display("idle done");
  endtask
  task automatic t_stop();
    wb(1'h1, pmc_pkg::PCTL_ADDR, 32'h0000_0003);
    wmode(pmc_pkg::PMC_STOP, 20);
    irq <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk("stop held", 32'(mode), 32'(pmc_pkg::PMC_STOP));
    irq <= 1'h0;
    wmode(pmc_pkg::PMC_RUN, 40);
    wb(1'h0, pmc_pkg::WAKE_ADDR, 32'h0000_0000);
    chk("wake reset", rd, 32'h0000_0006);
    $display("stop done");
  endtask
  task automatic t_susp();
    // Zero-tempco reference enable lives outside this block; firmware sets it first
    wb(1'h1, pmc_pkg::OSCC_ADDR, 32'h0000_0020);
    wmode(pmc_pkg::PMC_SUSPEND, 20);
    pm <= 1'h1;
    wmode(pmc_pkg::PMC_RUN, 5);
    chk("no wake irq", 32'(wirq), 32'h0000_0000);
    pm <= 1'h0;
    wb(1'h1, pmc_pkg::WAKE_ADDR, 32'h0000_0001);
    wb(1'h1, pmc_pkg::OSCC_ADDR, 32'h0000_0020);
    wmode(pmc_pkg::PMC_SUSPEND, 20);
    cmp <= 1'h0;
    irq <= 1'h1;
    wmode(pmc_pkg::PMC_RUN, 5);
    chk("wake irq", 32'(wirq), 32'h0000_0001);
    cmp <= 1'h1;
    irq <= 1'h0;
    wb(1'h1, pmc_pkg::OSCC_ADDR, 32'h0000_0020);
    wmode(pmc_pkg::PMC_SUSPEND, 20);
    xrst <= 1'h1;
    @(posedge clk_i);
    xrst <= 1'h0;
    wmode(pmc_pkg::PMC_RUN, 5);
    chk("susp reset", 32'(srst), 32'h0000_0001);
    chk("restart pc", 32'(rpc), 32'h0000_0000);
    wb(1'h0, pmc_pkg::WAKE_ADDR, 32'h0000_0000);
    chk("wake after reset", rd, 32'h0000_0006);
    $display("suspend done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs();
    t_idle();
    t_stop();
    t_susp();
    close_out();
  end
  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
